//--- pkg/tx_frontend_pkg.sv
// constants, register map and state types for the tx front-end register bank
// Functional notes
// - power index selects one of eight table entries
// - ask one symbols use the selected entry
// - ask zero symbols use entry zero
// - step entries zero to index for ramping
// - lo buffer current field bits 5:4, reset 01
// - calibration config register, result loaded, reset a9
// - mid and low results six bits, read/write
// - host-written calibration values replace new calibration
// - calibration control five bits, reset 0d
// - writing bf enables temperature sensor in idle
package tx_frontend_pkg;

  localparam int num_regs = 9;

  typedef logic [5:0] reg_index_t;
  typedef logic [7:0] reg_byte_t;

  // entry numbers inside the register array
  localparam int ent_front_end = 0;
  localparam int ent_cal_config = 1;
  localparam int ent_cal_mid = 2;
  localparam int ent_cal_low = 3;
  localparam int ent_cal_control = 4;
  localparam int ent_synth_test = 5;
  localparam int ent_prod_test = 6;
  localparam int ent_test_high = 7;
  localparam int ent_test_mid = 8;

  // register indices; byte address is four times the index
  localparam reg_index_t reg_index_tbl [0:8] = '{
    6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h29, 6'h2a, 6'h2c, 6'h2d};
  localparam reg_byte_t reg_reset_tbl [0:8] = '{
    8'h10, 8'ha9, 8'h0a, 8'h20, 8'h0d, 8'h57, 8'h7f, 8'h88, 8'h21};
  // writable bits; everything else is reserved and reads zero
  localparam reg_byte_t reg_mask_tbl [0:8] = '{
    8'h37, 8'hff, 8'h3f, 8'h3f, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff};

  // field positions
  localparam int lo_buf_msb = 5;
  localparam int lo_buf_lsb = 4;
  localparam int power_index_msb = 2;
  localparam int cal_result_msb = 5;
  localparam int cal_ctrl_msb = 4;

  localparam reg_byte_t temp_sensor_code = 8'hbf;
  localparam reg_byte_t prod_test_default = 8'h7f;

  // ahb-lite address decode
  localparam int addr_index_lsb = 2;
  localparam int addr_index_msb = 7;
  localparam logic [23:0] addr_upper_zero = 24'h000000;
  localparam logic [1:0] addr_align_zero = 2'h0;
  localparam logic [31:0] rdata_zero = 32'h00000000;
  localparam logic [23:0] rdata_pad = 24'h000000;

  // power ramp step time
  localparam int clk_period_ns = 50;
  localparam int ramp_step_time_ns = 200;
  localparam int ramp_step_cycles =
    (ramp_step_time_ns + clk_period_ns - 1) / clk_period_ns;
  localparam logic [7:0] ramp_step_last = 8'(ramp_step_cycles - 1);

  typedef enum logic [1:0] {
    bus_addr = 2'b01,
    bus_data = 2'b10
  } bus_state_t;

  typedef enum logic [2:0] {
    ramp_hold = 3'b001,
    ramp_up   = 3'b010,
    ramp_down = 3'b100
  } ramp_state_t;

endpackage

//--- core/pa_ramp_sequencer.sv
// steps the power table entry toward the wanted one, one entry per step
`timescale 1ns/10ps
`default_nettype none
module pa_ramp_sequencer (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // radio side
  input  wire logic       tx_active,
  input  wire logic       ask_mode,
  input  wire logic       tx_symbol,
  input  wire logic [2:0] power_table_index,
  // amplifier side
  output logic      [2:0] table_entry,
  output logic            ramp_busy
);

  tx_frontend_pkg::ramp_state_t state_reg;
  tx_frontend_pkg::ramp_state_t state_next;
  logic [2:0] entry_reg;
  logic [2:0] entry_next;
  logic [2:0] target;
  logic [7:0] step_cnt_reg;
  logic [7:0] step_cnt_next;
  logic       busy_reg;
  logic       busy_next;

  always_comb begin
    target = 3'h0;
    if (tx_active) begin
      if (ask_mode && !tx_symbol) begin
        target = 3'h0;
      end else begin
        target = power_table_index;
      end
    end
    entry_next = entry_reg;
    step_cnt_next = 8'h00;
    // one entry per step so ask edges and tx start/end are shaped
    case (state_reg)
      tx_frontend_pkg::ramp_up,
      tx_frontend_pkg::ramp_down: begin
        if (step_cnt_reg == tx_frontend_pkg::ramp_step_last) begin
          // only step while the target still lies that way, no overshoot
          if (state_reg == tx_frontend_pkg::ramp_up) begin
            if (target > entry_reg) begin
              entry_next = entry_reg + 3'h1;
            end
          end else if (target < entry_reg) begin
            entry_next = entry_reg - 3'h1;
          end
        end else begin
          step_cnt_next = step_cnt_reg + 8'h01;
        end
      end
      default: begin
        step_cnt_next = 8'h00;
      end
    endcase
    if (target > entry_next) begin
      state_next = tx_frontend_pkg::ramp_up;
    end else if (target < entry_next) begin
      state_next = tx_frontend_pkg::ramp_down;
    end else begin
      state_next = tx_frontend_pkg::ramp_hold;
    end
    if (entry_next != entry_reg) begin
      step_cnt_next = 8'h00;
    end
    busy_next = (target != entry_next);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= tx_frontend_pkg::ramp_hold;
      entry_reg <= 3'h0;
      step_cnt_reg <= 8'h00;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      entry_reg <= entry_next;
      step_cnt_reg <= step_cnt_next;
      busy_reg <= busy_next;
    end
  end

  assign table_entry = entry_reg;
  assign ramp_busy = busy_reg;

endmodule
`default_nettype wire

//--- core/cal_hop_tracker.sv
// decides whether a calibration request runs or reuses host-written values
`timescale 1ns/10ps
`default_nettype none
module cal_hop_tracker (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // events
  input  wire logic host_cal_write,
  input  wire logic cal_result_valid,
  input  wire logic cal_start_request,
  // decisions
  output logic      host_cal_loaded,
  output logic      cal_start,
  output logic      cal_skipped
);

  logic loaded_reg;
  logic loaded_next;
  logic start_reg;
  logic start_next;
  logic skipped_reg;
  logic skipped_next;

  always_comb begin
    // a host write in the same cycle as a result wins
    if (host_cal_write) begin
      loaded_next = 1'b1;
    end else if (cal_result_valid) begin
      loaded_next = 1'b0;
    end else begin
      loaded_next = loaded_reg;
    end
    start_next = cal_start_request && !loaded_reg;
    skipped_next = cal_start_request && loaded_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loaded_reg <= 1'b0;
      start_reg <= 1'b0;
      skipped_reg <= 1'b0;
    end else begin
      loaded_reg <= loaded_next;
      start_reg <= start_next;
      skipped_reg <= skipped_next;
    end
  end

  assign host_cal_loaded = loaded_reg;
  assign cal_start = start_reg;
  assign cal_skipped = skipped_reg;

endmodule
`default_nettype wire

//--- core/tx_frontend_fscal_regs.sv
// tx front-end and synthesizer calibration register bank, ahb-lite slave
`timescale 1ns/10ps
`default_nettype none
module tx_frontend_fscal_regs (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // radio control side
  input  wire logic        tx_active,
  input  wire logic        ask_mode,
  input  wire logic        tx_symbol,
  input  wire logic        radio_idle,
  // calibration engine side
  input  wire logic        cal_start_request,
  input  wire logic        cal_result_valid,
  input  wire logic [7:0]  cal_result_config,
  input  wire logic [5:0]  cal_result_mid,
  input  wire logic [5:0]  cal_result_low,
  output logic             cal_start,
  output logic             cal_skipped,
  output logic             host_cal_loaded,
  // analog settings
  output logic      [1:0]  lo_buffer_current,
  output logic      [2:0]  pa_table_entry,
  output logic             pa_ramp_busy,
  output logic      [7:0]  synth_cal_config_value,
  output logic      [5:0]  synth_cal_mid_value,
  output logic      [5:0]  synth_cal_low_value,
  output logic      [4:0]  synth_cal_control_value,
  output logic      [7:0]  synth_test_value,
  output logic      [7:0]  production_test_value,
  output logic      [7:0]  misc_test_high_value,
  output logic      [7:0]  misc_test_mid_value,
  output logic             temp_sensor_enable
);

  localparam int n = tx_frontend_pkg::num_regs;

  // bus state
  tx_frontend_pkg::bus_state_t state_reg;
  tx_frontend_pkg::bus_state_t state_next;
  tx_frontend_pkg::reg_index_t addr_index_reg;
  tx_frontend_pkg::reg_index_t addr_index_next;
  logic        write_reg;
  logic        write_next;
  logic        mapped_reg;
  logic        mapped_next;
  logic        hreadyout_reg;
  logic        hreadyout_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic        hresp_reg;
  logic        hresp_next;

  // decode helpers
  tx_frontend_pkg::reg_index_t req_index;
  logic        req_mapped;
  logic        accept;
  logic        wr_en;
  logic [7:0]  rd_value;
  logic        host_cal_write;
  logic        req_hit  [0:n-1];
  logic        sel_hit  [0:n-1];
  logic        wr_hit   [0:n-1];
  logic [7:0]  rd_part  [0:n-1];

  // register array
  logic [7:0]  reg_q    [0:n-1];
  logic [7:0]  reg_d    [0:n-1];
  logic        hw_load  [0:n-1];
  logic [7:0]  hw_value [0:n-1];

  // temperature sensor
  logic        temp_reg;
  logic        temp_next;

  assign req_index = haddr[tx_frontend_pkg::addr_index_msb:
                           tx_frontend_pkg::addr_index_lsb];

  always_comb begin
    req_mapped = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (req_hit[i]) begin
        req_mapped = 1'b1;
      end
    end
    // any address outside the word-aligned map is unmapped
    if (haddr[31:8] != tx_frontend_pkg::addr_upper_zero ||
        haddr[1:0] != tx_frontend_pkg::addr_align_zero) begin
      req_mapped = 1'b0;
    end
  end

  // hsize is not decoded: every access acts on the whole word
  assign accept = hsel && hready && htrans[1] &&
                  (state_reg == tx_frontend_pkg::bus_addr);

  // registered read data costs one wait state on every transfer
  always_comb begin
    state_next = state_reg;
    addr_index_next = addr_index_reg;
    write_next = write_reg;
    mapped_next = mapped_reg;
    hreadyout_next = hreadyout_reg;
    hrdata_next = hrdata_reg;
    hresp_next = 1'b0;
    case (state_reg)
      tx_frontend_pkg::bus_addr: begin
        if (accept) begin
          state_next = tx_frontend_pkg::bus_data;
          addr_index_next = req_index;
          write_next = hwrite;
          mapped_next = req_mapped;
          hreadyout_next = 1'b0;
        end
      end
      tx_frontend_pkg::bus_data: begin
        state_next = tx_frontend_pkg::bus_addr;
        hreadyout_next = 1'b1;
        if (!write_reg && mapped_reg) begin
          hrdata_next = {tx_frontend_pkg::rdata_pad, rd_value};
        end else begin
          hrdata_next = tx_frontend_pkg::rdata_zero;
        end
      end
      default: begin
        // a lost state falls back to the address phase with ready high
        state_next = tx_frontend_pkg::bus_addr;
        hreadyout_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= tx_frontend_pkg::bus_addr;
      addr_index_reg <= 6'h00;
      write_reg <= 1'b0;
      mapped_reg <= 1'b0;
      hreadyout_reg <= 1'b1;
      hrdata_reg <= 32'h00000000;
      hresp_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      addr_index_reg <= addr_index_next;
      write_reg <= write_next;
      mapped_reg <= mapped_next;
      hreadyout_reg <= hreadyout_next;
      hrdata_reg <= hrdata_next;
      hresp_reg <= hresp_next;
    end
  end

  // writes land at the end of the data phase, with hwdata stable
  assign wr_en = (state_reg == tx_frontend_pkg::bus_data) &&
                 write_reg && mapped_reg;

  // read back; stored values already hold zero in reserved bits
  always_comb begin
    rd_value = 8'h00;
    for (int i = 0; i < n; i++) begin
      if (sel_hit[i]) begin
        rd_value = rd_part[i];
      end
    end
  end

  assign host_cal_write = wr_en && (
    addr_index_reg ==
      tx_frontend_pkg::reg_index_tbl[tx_frontend_pkg::ent_cal_config] ||
    addr_index_reg ==
      tx_frontend_pkg::reg_index_tbl[tx_frontend_pkg::ent_cal_mid] ||
    addr_index_reg ==
      tx_frontend_pkg::reg_index_tbl[tx_frontend_pkg::ent_cal_low]);

  // calibration results reload the three hop registers
  always_comb begin
    for (int i = 0; i < n; i++) begin
      hw_load[i] = 1'b0;
      hw_value[i] = 8'h00;
    end
    hw_load[tx_frontend_pkg::ent_cal_config] = cal_result_valid;
    hw_value[tx_frontend_pkg::ent_cal_config] = cal_result_config;
    hw_load[tx_frontend_pkg::ent_cal_mid] = cal_result_valid;
    // the zero pad keeps the reserved top bits of mid and low clear
    hw_value[tx_frontend_pkg::ent_cal_mid] = {2'h0, cal_result_mid};
    hw_load[tx_frontend_pkg::ent_cal_low] = cal_result_valid;
    hw_value[tx_frontend_pkg::ent_cal_low] = {2'h0, cal_result_low};
  end

  // test registers stay writable; keeping off them is up to software
  genvar g;
  generate
    for (g = 0; g < n; g++) begin : gen_reg
      // one hit per entry, for the address phase and the data phase
      always_comb begin
        req_hit[g] = (req_index == tx_frontend_pkg::reg_index_tbl[g]);
        sel_hit[g] = (addr_index_reg == tx_frontend_pkg::reg_index_tbl[g]);
        wr_hit[g] = wr_en && sel_hit[g];
        rd_part[g] = reg_q[g] & tx_frontend_pkg::reg_mask_tbl[g];
      end

      always_comb begin
        // a host write beats a calibration result in the same cycle
        if (wr_hit[g]) begin
          reg_d[g] = hwdata[7:0] & tx_frontend_pkg::reg_mask_tbl[g];
        end else if (hw_load[g]) begin
          reg_d[g] = hw_value[g] & tx_frontend_pkg::reg_mask_tbl[g];
        end else begin
          reg_d[g] = reg_q[g];
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          reg_q[g] <= tx_frontend_pkg::reg_reset_tbl[g];
        end else begin
          reg_q[g] <= reg_d[g];
        end
      end
    end
  endgenerate

  // sensor only in idle, so a forgotten restore cannot leak into tx
  always_comb begin
    temp_next = radio_idle && (reg_q[tx_frontend_pkg::ent_prod_test] ==
                               tx_frontend_pkg::temp_sensor_code);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      temp_reg <= 1'b0;
    end else begin
      temp_reg <= temp_next;
    end
  end

  // the sequencer only sees the three index bits, never the reserved bit
  pa_ramp_sequencer u_ramp (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .tx_active         (tx_active),
    .ask_mode          (ask_mode),
    .tx_symbol         (tx_symbol),
    .power_table_index (reg_q[tx_frontend_pkg::ent_front_end]
                         [tx_frontend_pkg::power_index_msb:0]),
    .table_entry       (pa_table_entry),
    .ramp_busy         (pa_ramp_busy)
  );

  cal_hop_tracker u_hop (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .host_cal_write    (host_cal_write),
    .cal_result_valid  (cal_result_valid),
    .cal_start_request (cal_start_request),
    .host_cal_loaded   (host_cal_loaded),
    .cal_start         (cal_start),
    .cal_skipped       (cal_skipped)
  );

  // bus outputs
  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;

  // analog settings straight from the register flops
  assign lo_buffer_current = reg_q[tx_frontend_pkg::ent_front_end]
    [tx_frontend_pkg::lo_buf_msb:tx_frontend_pkg::lo_buf_lsb];
  assign synth_cal_config_value = reg_q[tx_frontend_pkg::ent_cal_config];
  assign synth_cal_mid_value = reg_q[tx_frontend_pkg::ent_cal_mid]
    [tx_frontend_pkg::cal_result_msb:0];
  assign synth_cal_low_value = reg_q[tx_frontend_pkg::ent_cal_low]
    [tx_frontend_pkg::cal_result_msb:0];
  assign synth_cal_control_value = reg_q[tx_frontend_pkg::ent_cal_control]
    [tx_frontend_pkg::cal_ctrl_msb:0];
  assign synth_test_value = reg_q[tx_frontend_pkg::ent_synth_test];
  assign production_test_value = reg_q[tx_frontend_pkg::ent_prod_test];
  assign misc_test_high_value = reg_q[tx_frontend_pkg::ent_test_high];
  assign misc_test_mid_value = reg_q[tx_frontend_pkg::ent_test_mid];
  assign temp_sensor_enable = temp_reg;

endmodule
`default_nettype wire

//--- test/tx_frontend_fscal_regs_properties.sv
// concurrent checks on the tx front-end register bank ports
`timescale 1ns/10ps
`default_nettype none
module tx_frontend_fscal_regs_properties (
  // clock and bus
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  // radio and calibration
  input wire logic       tx_active,
  input wire logic       radio_idle,
  input wire logic       cal_start_request,
  input wire logic       cal_result_valid,
  input wire logic [7:0] cal_result_config,
  input wire logic [5:0] cal_result_mid,
  input wire logic [5:0] cal_result_low,
  input wire logic       cal_start,
  input wire logic       cal_skipped,
  input wire logic       host_cal_loaded,
  // settings
  input wire logic [2:0] pa_table_entry,
  input wire logic       pa_ramp_busy,
  input wire logic [7:0] synth_cal_config_value,
  input wire logic [5:0] synth_cal_mid_value,
  input wire logic [5:0] synth_cal_low_value,
  input wire logic [7:0] production_test_value,
  input wire logic       temp_sensor_enable
);
  logic       take;
  logic       wr_phase_reg;
  logic       wr_phase_next;
  logic [5:0] idle_cnt_reg;
  logic [5:0] idle_cnt_next;

  assign take = hsel && hready && htrans[1] && hreadyout;

  // host write wins over a result load, so skip loads during a write
  always_comb begin
    wr_phase_next = take && hwrite;
    idle_cnt_next = idle_cnt_reg;
    if (tx_active) begin
      idle_cnt_next = 6'h00;
    end else if (idle_cnt_reg != 6'h3f) begin
      idle_cnt_next = idle_cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_phase_reg <= 1'h0;
      idle_cnt_reg <= 6'h00;
    end else begin
      wr_phase_reg <= wr_phase_next;
      idle_cnt_reg <= idle_cnt_next;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  bus_okay_a: assert property (hresp == 1'h0)
    else $error("error response seen");
  wait_state_a: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("wait state not exactly one cycle");
  cal_run_a: assert property (
    cal_start_request && !host_cal_loaded |=> cal_start && !cal_skipped)
    else $error("calibration not started");
  cal_reuse_a: assert property (
    cal_start_request && host_cal_loaded |=> cal_skipped && !cal_start)
    else $error("calibration not skipped");
  cal_quiet_a: assert property (
    !cal_start_request |=> !cal_start && !cal_skipped)
    else $error("calibration pulse without request");
  cal_load_a: assert property (
    cal_result_valid && !wr_phase_reg |=>
      synth_cal_config_value == $past(cal_result_config) &&
      synth_cal_mid_value == $past(cal_result_mid) &&
      synth_cal_low_value == $past(cal_result_low) && !host_cal_loaded)
    else $error("calibration result not loaded");
  sensor_on_a: assert property (
    production_test_value == 8'hbf && radio_idle |=> temp_sensor_enable)
    else $error("temperature sensor not enabled");
  sensor_off_a: assert property (
    production_test_value != 8'hbf || !radio_idle |=> !temp_sensor_enable)
    else $error("temperature sensor enabled wrongly");
  ramp_step_a: assert property (
    $changed(pa_table_entry) |->
      pa_table_entry == $past(pa_table_entry) + 3'h1 ||
      pa_table_entry == $past(pa_table_entry) - 3'h1)
    else $error("power entry skipped a step");
  ramp_home_a: assert property (
    idle_cnt_reg >= 6'h28 |-> pa_table_entry == 3'h0 && !pa_ramp_busy)
    else $error("power entry not back at zero");

  cover property (cal_skipped);
  cover property (temp_sensor_enable);
  cover property (pa_table_entry == 3'h7);
endmodule

bind tx_frontend_fscal_regs tx_frontend_fscal_regs_properties
  i_tx_frontend_fscal_regs_properties (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
  .tx_active, .radio_idle, .cal_start_request, .cal_result_valid,
  .cal_result_config, .cal_result_mid, .cal_result_low, .cal_start,
  .cal_skipped, .host_cal_loaded, .pa_table_entry, .pa_ramp_busy,
  .synth_cal_config_value, .synth_cal_mid_value, .synth_cal_low_value,
  .production_test_value, .temp_sensor_enable);
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the tx front-end register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        tx_active;
  logic        ask_mode;
  logic        tx_symbol;
  logic        radio_idle;
  logic        cal_start_request;
  logic        cal_result_valid;
  logic [7:0]  cal_result_config;
  logic [5:0]  cal_result_mid;
  logic [5:0]  cal_result_low;
  logic        cal_start;
  logic        cal_skipped;
  logic        host_cal_loaded;
  logic [1:0]  lo_buffer_current;
  logic [2:0]  pa_table_entry;
  logic        pa_ramp_busy;
  logic [7:0]  synth_cal_config_value;
  logic [5:0]  synth_cal_mid_value;
  logic [5:0]  synth_cal_low_value;
  logic [4:0]  synth_cal_control_value;
  logic [7:0]  synth_test_value;
  logic [7:0]  production_test_value;
  logic [7:0]  misc_test_high_value;
  logic [7:0]  misc_test_mid_value;
  logic        temp_sensor_enable;
  logic [31:0] rd;
  int          failures;
  int          checked;
  int          cycles = 0;
  localparam logic [7:0] rst_tbl [0:8] = '{8'h10, 8'ha9, 8'h0a, 8'h20,
    8'h0d, 8'h57, 8'h7f, 8'h88, 8'h21};
  localparam logic [7:0] mask_tbl [0:4] = '{8'h37, 8'hff, 8'h3f, 8'h3f,
    8'h1f};

  tx_frontend_fscal_regs i_tx_frontend_fscal_regs (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .tx_active,
    .ask_mode, .tx_symbol, .radio_idle, .cal_start_request,
    .cal_result_valid, .cal_result_config, .cal_result_mid,
    .cal_result_low, .cal_start, .cal_skipped, .host_cal_loaded,
    .lo_buffer_current, .pa_table_entry, .pa_ramp_busy,
    .synth_cal_config_value, .synth_cal_mid_value, .synth_cal_low_value,
    .synth_cal_control_value, .synth_test_value, .production_test_value,
    .misc_test_high_value, .misc_test_mid_value, .temp_sensor_enable);

  task automatic close_out;
    if (failures == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one single transfer; byte address is four times the index
  task automatic xfer(input logic [5:0] idx, input logic wr,
                      input logic [7:0] wd);
    hsel <= 1'h1;
    haddr <= {24'h000000, idx, 2'h0};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
    xfer(idx, 1'h0, 8'h00);
    chk(rd, {24'h000000, exp});
  endtask

  // bounded wait: a full ramp of seven steps needs under 64 cycles
  task automatic ramp(input logic tx, input logic ask, input logic sym,
                      input logic [2:0] exp);
    int k;
    k = 0;
    tx_active <= tx;
    ask_mode <= ask;
    tx_symbol <= sym;
    repeat (2) @(posedge hclk);
    while (pa_ramp_busy !== 1'h0 && k < 64) begin
      @(posedge hclk);
      k++;
    end
    chk({28'h0, pa_ramp_busy, pa_table_entry}, {29'h0, exp});
  endtask

  task automatic pulse_req(input logic run);
    cal_start_request <= 1'h1;
    @(posedge hclk);
    cal_start_request <= 1'h0;
    #1;
    chk({30'h0, cal_start, cal_skipped}, {30'h0, run, !run});
    @(posedge hclk);
  endtask

  initial begin
    hclk = 1'h0;
    forever #25 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("[FAIL] %0t run timed out", $time);
      close_out;
    end
  end

  initial begin
    failures = 0;
    checked = 0;
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    tx_active = 1'h0;
    ask_mode = 1'h0;
    tx_symbol = 1'h0;
    radio_idle = 1'h0;
    cal_start_request = 1'h0;
    cal_result_valid = 1'h0;
    cal_result_config = 8'h00;
    cal_result_mid = 6'h00;
    cal_result_low = 6'h00;
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    for (int i = 0; i < 9; i++) begin
      rd_chk(tx_frontend_pkg::reg_index_tbl[i], rst_tbl[i]);
    end
    chk({27'h0, synth_cal_control_value}, 32'h0000000d);
    chk({synth_test_value, misc_test_high_value, misc_test_mid_value,
         8'h00}, 32'h57882100);
    // test registers are left out of this loop; the production test one is written below
    for (int i = 0; i < 5; i++) begin
      xfer(tx_frontend_pkg::reg_index_tbl[i], 1'h1, 8'hff);
      rd_chk(tx_frontend_pkg::reg_index_tbl[i], mask_tbl[i]);
    end
    rd_chk(6'h27, 8'h00);
    xfer(6'h27, 1'h1, 8'h55);
    rd_chk(6'h26, 8'h1f);
    xfer(6'h22, 1'h1, 8'h2b);
    rd_chk(6'h22, 8'h23);
    chk({30'h0, lo_buffer_current}, 32'h00000002);
    ramp(1'h1, 1'h0, 1'h0, 3'h3);
    ramp(1'h1, 1'h1, 1'h0, 3'h0);
    ramp(1'h1, 1'h1, 1'h1, 3'h3);
    ramp(1'h0, 1'h0, 1'h0, 3'h0);
    xfer(6'h22, 1'h1, 8'h17);
    ramp(1'h1, 1'h0, 1'h0, 3'h7);
    ramp(1'h0, 1'h0, 1'h0, 3'h0);
    cal_result_config <= 8'h3c;
    cal_result_mid <= 6'h15;
    cal_result_low <= 6'h2e;
    cal_result_valid <= 1'h1;
    @(posedge hclk);
    cal_result_valid <= 1'h0;
    rd_chk(6'h23, 8'h3c);
    rd_chk(6'h24, 8'h15);
    rd_chk(6'h25, 8'h2e);
    chk({8'h00, synth_cal_config_value, 2'h0, synth_cal_mid_value,
         2'h0, synth_cal_low_value}, 32'h003c152e);
    chk({31'h0, host_cal_loaded}, 32'h00000000);
    pulse_req(1'h1);
    xfer(6'h24, 1'h1, 8'h07);
    pulse_req(1'h0);
    rd_chk(6'h24, 8'h07);
    chk({26'h0, synth_cal_mid_value}, 32'h00000007);
    radio_idle <= 1'h1;
    xfer(6'h2a, 1'h1, 8'hbf);
    repeat (2) @(posedge hclk);
    chk({31'h0, temp_sensor_enable}, 32'h00000001);
    xfer(6'h2a, 1'h1, 8'h7f);
    repeat (2) @(posedge hclk);
    chk({31'h0, temp_sensor_enable}, 32'h00000000);
    rd_chk(6'h2a, 8'h7f);
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    rd_chk(6'h24, 8'h0a);
    chk({31'h0, host_cal_loaded}, 32'h00000000);
    close_out;
  end
endmodule
`default_nettype wire
